// ### verilog/addr_data_port_pair.v
/*
  address port and data port pair: register file, standby and reset
  retention, mode-dependent pin functions and pull-ups.
  assumes mode pins are static straps, bus controller on core_clk.
*/
`timescale 1ns/1ps
`include "addr_data_port_map.vh"
// Summary of operation
// - address port pull-up register, retained by soft resets
// - address pull-ups only in modes six, seven
// - pull-up on when direction 0, pull bit 1
// - pull-ups off at power-on and hardware standby
// - output and address pins never pulled up
// - modes four, five: address port all address
// - mode six: direction picks address or input
// - mode seven: address port plain I/O
// - data direction write-only, reads undefined
// - data direction cleared only by hard reset
// - modes four to six: data bus pins
// - mode seven: data direction picks output/input
// - data output register, retained by soft resets
// - pin-read register read-only, writes ignored
// - read returns output bit or pin level
// - pin-read frozen in manual reset, software standby
// - data port pull-up register, reset to zero
// - data pull-ups only mode seven inputs
// - address pin read: output bit or pin
module addr_data_port_pair #(
  parameter W = 8
) (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire hw_standby,
  input wire manual_reset,
  input wire sw_standby,
  input wire [`ADP_MODE_W-1:0] op_mode,
  input wire [`ADP_AW-1:0] reg_addr,
  input wire [W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [W-1:0] reg_rdata,
  input wire [W-1:0] addr_dir,
  input wire [W-1:0] addr_port_out,
  input wire [W-1:0] bus_addr_out,
  input wire [W-1:0] bus_data_out,
  input wire [W-1:0] bus_data_oe_n,
  input wire [W-1:0] addr_pin_in,
  output wire [W-1:0] addr_pin_out,
  output wire [W-1:0] addr_pin_oe_n,
  output wire [W-1:0] addr_pullup_en,
  output wire [W-1:0] addr_port_pin_level,
  input wire [W-1:0] data_pin_in,
  output wire [W-1:0] data_pin_out,
  output wire [W-1:0] data_pin_oe_n,
  output wire [W-1:0] data_pullup_en
);
  reg [W-1:0] address_port_pullup_control_r;
  reg [W-1:0] data_port_direction_r;
  reg [W-1:0] data_port_pullup_control_r;
  reg [W-1:0] data_port_output_value_r;
  reg [W-1:0] data_pin_view_r;
  reg [W-1:0] addr_pin_view_r;
  wire [W-1:0] data_pin_sync;
  wire [W-1:0] addr_pin_sync;

  function sel_hit;
    input [`ADP_AW-1:0] a;
    input [`ADP_AW-1:0] ofs;
    begin
      sel_hit = (a == ofs);
    end
  endfunction

  // hardware standby acts like power-on for everything it clears
  wire hard_clr = hw_standby;
  wire frozen = manual_reset | sw_standby;
  wire wr_ok = reg_wr & ~frozen;
  wire m45 = (op_mode == `ADP_MODE_4) | (op_mode == `ADP_MODE_5);
  wire m6 = (op_mode == `ADP_MODE_6);
  wire m7 = (op_mode == `ADP_MODE_7);

  pin_sync3 #(.W(W)) u_dsync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(data_pin_in),
    .pin_sync(data_pin_sync)
  );

  pin_sync3 #(.W(W)) u_async (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(addr_pin_in),
    .pin_sync(addr_pin_sync)
  );

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      address_port_pullup_control_r <= `ADP_RST_VAL;
      data_port_direction_r <= `ADP_RST_VAL;
      data_port_output_value_r <= `ADP_RST_VAL;
      data_port_pullup_control_r <= `ADP_RST_VAL;
    end else if (clk_en) begin
      if (hard_clr) begin
        address_port_pullup_control_r <= `ADP_RST_VAL;
        data_port_direction_r <= `ADP_RST_VAL;
        data_port_output_value_r <= `ADP_RST_VAL;
        data_port_pullup_control_r <= `ADP_RST_VAL;
      end else if (wr_ok) begin
        if (sel_hit(reg_addr, `ADP_OFS_A_PCR))
          address_port_pullup_control_r <= reg_wdata;
        if (sel_hit(reg_addr, `ADP_OFS_D_DIR))
          data_port_direction_r <= reg_wdata;
        if (sel_hit(reg_addr, `ADP_OFS_D_OUT))
          data_port_output_value_r <= reg_wdata;
        if (sel_hit(reg_addr, `ADP_OFS_D_PCR))
          data_port_pullup_control_r <= reg_wdata;
      end
    end
  end

  // pin views track the merged value except while frozen
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_pin_view_r <= `ADP_RST_VAL;
      addr_pin_view_r <= `ADP_RST_VAL;
    end else if (clk_en && !frozen) begin
      data_pin_view_r <= (data_port_direction_r & data_port_output_value_r)
        | (~data_port_direction_r & data_pin_sync);
      addr_pin_view_r <= (addr_dir & addr_port_out) | (~addr_dir & addr_pin_sync);
    end
  end

  assign addr_port_pin_level = addr_pin_view_r;

  // read data stand one cycle after the strobe only
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `ADP_RST_VAL;
    end else if (clk_en) begin
      reg_rdata <= `ADP_RST_VAL;
      if (reg_rd) begin
        if (sel_hit(reg_addr, `ADP_OFS_A_PCR))
          reg_rdata <= address_port_pullup_control_r;
        else if (sel_hit(reg_addr, `ADP_OFS_D_DIR))
          reg_rdata <= `ADP_UNDEF_VAL;
        else if (sel_hit(reg_addr, `ADP_OFS_D_OUT))
          reg_rdata <= data_port_output_value_r;
        else if (sel_hit(reg_addr, `ADP_OFS_D_PCR))
          reg_rdata <= data_port_pullup_control_r;
        else if (sel_hit(reg_addr, `ADP_OFS_D_PIN))
          reg_rdata <= data_pin_view_r;
        else if (sel_hit(reg_addr, `ADP_OFS_A_DIR))
          reg_rdata <= `ADP_UNDEF_VAL;
      end
    end
  end

  // address port: modes 4/5 all address, mode 6 dir picks address
  wire [W-1:0] a_sel = m6 ? addr_dir : {W{1'b0}};
  wire [W-1:0] a_oe_n = {W{1'b0}};

  port_pin_mux #(.W(W)) u_amux (
    .bus_owns(m45),
    .bus_sel(a_sel),
    .port_io(m7),
    .pull_ok((m6 | m7) & ~hard_clr),
    .dir(addr_dir),
    .pcr(address_port_pullup_control_r),
    .port_out(addr_port_out),
    .bus_out(bus_addr_out),
    .bus_oe_n(a_oe_n),
    .pin_out(addr_pin_out),
    .pin_oe_n(addr_pin_oe_n),
    .pullup_en(addr_pullup_en)
  );

  // data port: modes 4-6 bus owns, direction ignored
  port_pin_mux #(.W(W)) u_dmux (
    .bus_owns(~m7),
    .bus_sel({W{1'b0}}),
    .port_io(m7),
    .pull_ok(m7 & ~hard_clr),
    .dir(data_port_direction_r),
    .pcr(data_port_pullup_control_r),
    .port_out(data_port_output_value_r),
    .bus_out(bus_data_out),
    .bus_oe_n(bus_data_oe_n),
    .pin_out(data_pin_out),
    .pin_oe_n(data_pin_oe_n),
    .pullup_en(data_pullup_en)
  );
endmodule // addr_data_port_pair

// ### verilog/addr_data_port_map.vh
/*
  register offsets, widths, reset values and mode codes for the
  address/data port pair. assumes a 16-bit register address port.
*/
`ifndef ADDR_DATA_PORT_MAP_VH
`define ADDR_DATA_PORT_MAP_VH
`define ADP_AW 16
`define ADP_DW 8
`define ADP_OFS_D_DIR 16'hfe3c
`define ADP_OFS_D_PCR 16'hfe43
`define ADP_OFS_D_OUT 16'hff0c
`define ADP_OFS_D_PIN 16'hffbc
`define ADP_OFS_A_PCR 16'hfe42
`define ADP_OFS_A_DIR 16'hfe3b
`define ADP_RST_VAL 8'h00
`define ADP_UNDEF_VAL 8'hff
`define ADP_MODE_W 3
`define ADP_MODE_4 3'h4
`define ADP_MODE_5 3'h5
`define ADP_MODE_6 3'h6
`define ADP_MODE_7 3'h7
`endif

// ### verilog/pin_sync3.v
/*
  three-stage synchroniser for a bus of pin inputs with agreement filter.
  assumes pins are asynchronous to core_clk.
*/
`timescale 1ns/1ps
module pin_sync3 #(
  parameter W = 8
) (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] pin_sync
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      pin_sync <= {W{1'b0}};
    end else if (clk_en) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // glitch filter: only take bits where stages two and three agree
      pin_sync <= (pin_sync & ~(s2_r ~^ s3_r)) | (s2_r & (s2_r ~^ s3_r));
    end
  end
endmodule // pin_sync3

// ### verilog/port_pin_mux.v
/*
  per-pin function mux for one 8-bit port: picks bus or port drive and
  computes pull-up enables. assumes decoded mode flags from the top.
*/
`timescale 1ns/1ps
module port_pin_mux #(
  parameter W = 8
) (
  input wire bus_owns,
  input wire [W-1:0] bus_sel,
  input wire port_io,
  input wire pull_ok,
  input wire [W-1:0] dir,
  input wire [W-1:0] pcr,
  input wire [W-1:0] port_out,
  input wire [W-1:0] bus_out,
  input wire [W-1:0] bus_oe_n,
  output wire [W-1:0] pin_out,
  output wire [W-1:0] pin_oe_n,
  output wire [W-1:0] pullup_en
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_pin
      wire by_bus = bus_owns | bus_sel[i];
      assign pin_out[i] = by_bus ? bus_out[i] : port_out[i];
      assign pin_oe_n[i] = by_bus ? bus_oe_n[i] : ~(port_io & dir[i]);
      // pull-up only on a general input; outputs never pulled
      assign pullup_en[i] = pull_ok & ~by_bus & ~dir[i] & pcr[i];
    end
  endgenerate
endmodule // port_pin_mux

// ### tb/adp_chk_sva.sv
/* checker for pin functions and register reads of the port pair.
   assumes one core_clk domain; bound into the top by port names */
`timescale 1ns/1ps
module adp_chk (
  input wire core_clk,
  input wire rst_n,
  input wire hw_standby,
  input wire [2:0] op_mode,
  input wire [15:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [7:0] addr_dir,
  input wire [7:0] addr_port_out,
  input wire [7:0] bus_addr_out,
  input wire [7:0] bus_data_out,
  input wire [7:0] bus_data_oe_n,
  input wire [7:0] addr_pin_out,
  input wire [7:0] addr_pin_oe_n,
  input wire [7:0] addr_pullup_en,
  input wire [7:0] data_pin_out,
  input wire [7:0] data_pin_oe_n,
  input wire [7:0] data_pullup_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence dir_read;
    reg_rd && reg_addr == 16'hfe3c;
  endsequence
  sequence hard_stby;
    hw_standby ##1 hw_standby;
  endsequence
  a_addr_all_bus: assert property (op_mode inside {3'h4, 3'h5} |->
    addr_pin_oe_n == 8'h00 && addr_pin_out == bus_addr_out) else $error("address bus pins wrong");
  a_addr_mode6: assert property (op_mode == 3'h6 |-> addr_pin_oe_n == ~addr_dir &&
    (addr_pin_out & addr_dir) == (bus_addr_out & addr_dir)) else $error("mode 6 address pins wrong");
  a_addr_plain_io: assert property (op_mode == 3'h7 |-> addr_pin_oe_n == ~addr_dir &&
    (addr_pin_out & addr_dir) == (addr_port_out & addr_dir)) else $error("mode 7 address pins wrong");
  a_addr_pull_mode: assert property (op_mode inside {3'h4, 3'h5} |-> addr_pullup_en == 8'h00)
    else $error("address pull-up in bus mode");
  a_addr_pull_out: assert property ((addr_pullup_en & addr_dir) == 8'h00)
    else $error("pull-up on output pin");
  a_data_bus_pins: assert property (op_mode inside {[3'h4:3'h6]} |-> data_pin_oe_n == bus_data_oe_n &&
    data_pin_out == bus_data_out && data_pullup_en == 8'h00) else $error("data bus pins wrong");
  a_data_pull_out: assert property ((data_pullup_en & ~data_pin_oe_n) == 8'h00)
    else $error("pull-up on driven data pin");
  a_dir_undef: assert property (dir_read |=> reg_rdata == 8'hff)
    else $error("direction read not undefined value");
  a_hw_pull_off: assert property (hard_stby |-> (addr_pullup_en | data_pullup_en) == 8'h00)
    else $error("pull-up on in hardware standby");
endmodule // adp_chk
bind addr_data_port_pair adp_chk i_chk (.*);

// ### tb/pin_side.sv
/* far side: bus controller with random cycles and the pin wires.
   assumes the bench supplies the external pin levels */
`timescale 1ns/1ps
module pin_side (
  input wire core_clk,
  input wire [7:0] ext,
  input wire [7:0] apo,
  input wire [7:0] aoe,
  input wire [7:0] dpo,
  input wire [7:0] doe,
  output reg [7:0] bao = 8'h00,
  output reg [7:0] bdo = 8'h00,
  output reg [7:0] bdoe = 8'h00,
  output wire [7:0] api,
  output wire [7:0] dpi
);
  integer s = 85;
  always @(posedge core_clk) begin
    bao <= $random(s);
    bdo <= $random(s);
    bdoe <= $random(s);
  end
  // driven bits win, the rest follow the outside world
  assign api = (~aoe & apo) | (aoe & ext);
  assign dpi = (~doe & dpo) | (doe & ext);
endmodule // pin_side

// ### tb/addr_data_port_pair_tb_top.sv
/* bench for the port pair: registers, modes, standby retention.
   assumes pin_side partner and the bound checker */
`timescale 1ns/1ps
module addr_data_port_pair_tb_top;
  reg core_clk, rst_n, hw_standby, manual_reset, sw_standby, reg_wr, reg_rd;
  reg [2:0] op_mode;
  reg [15:0] reg_addr;
  reg [7:0] reg_wdata, addr_dir, addr_port_out, ext, ek, dd, dv, dp, ap;
  wire [7:0] rdata, bao, bdo, bdoe, api, dpi, apo, aoe, ape, dpo, doe, dpe, apl;
  integer error_cnt = 0, comparisons = 0, seed = 85, i;
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  pin_side i_pins (.core_clk(core_clk), .ext(ext), .apo(apo), .aoe(aoe), .dpo(dpo), .doe(doe),
    .bao(bao), .bdo(bdo), .bdoe(bdoe), .api(api), .dpi(dpi));
  addr_data_port_pair i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .hw_standby(hw_standby),
    .manual_reset(manual_reset), .sw_standby(sw_standby), .op_mode(op_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .addr_dir(addr_dir),
    .addr_port_out(addr_port_out), .bus_addr_out(bao), .bus_data_out(bdo), .bus_data_oe_n(bdoe),
    .addr_pin_in(api), .addr_pin_out(apo), .addr_pin_oe_n(aoe), .addr_pullup_en(ape),
    .addr_port_pin_level(apl), .data_pin_in(dpi), .data_pin_out(dpo), .data_pin_oe_n(doe), .data_pullup_en(dpe));
  task chk(input [7:0] seen, input [7:0] exp, input [63:0] nm);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // tasks start and end on a rising edge; one idle cycle keeps strobes apart
  task wr(input [15:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(rdata, e, "rdata");
      @(posedge core_clk);
    end
  endtask
  task close_out;
    begin
      if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    {rst_n, hw_standby, manual_reset, sw_standby, reg_wr, reg_rd} = 6'h00;
    op_mode = 3'h7; reg_addr = 16'h0000; reg_wdata = 8'h00;
    addr_dir = 8'h00; addr_port_out = 8'h00; ext = 8'h00;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(16'hfe3c, 8'hff);
    rd(16'hfe43, 8'h00);
    rd(16'hff0c, 8'h00);
    rd(16'hfe42, 8'h00);
    for (i = 0; i < 40; i = i + 1) begin
      dd = (i < 2) ? {8{i[0]}} : $random(seed);
      {dv, dp, ap} = $random(seed);
      op_mode <= 3'h4 + i[1:0];
      addr_dir <= $random(seed); addr_port_out <= $random(seed); ext <= $random(seed);
      wr(16'hfe3c, dd); wr(16'hff0c, dv); wr(16'hfe43, dp); wr(16'hfe42, ap);
      wr(16'hffbc, ~dv);
      repeat (5) @(posedge core_clk);
      rd(16'hff0c, dv);
      rd(16'hfe43, dp);
      rd(16'hfe42, ap);
      @(negedge core_clk);
      chk(ape, (op_mode > 3'h5) ? (~addr_dir & ap) : 8'h00, "apull");
      if (op_mode > 3'h5)
        chk(apl, (addr_dir & addr_port_out) | (~addr_dir & ext), "apin");
      if (op_mode == 3'h7) begin
        chk(dpe, ~dd & dp, "dpull");
        chk(doe, ~dd, "doe");
      end
      @(posedge core_clk);
      if (op_mode == 3'h7)
        rd(16'hffbc, (dd & dv) | (~dd & ext));
    end
    ek = ext;
    for (i = 0; i < 2; i = i + 1) begin
      {sw_standby, manual_reset} <= i[0] ? 2'b10 : 2'b01;
      ext <= ~ext;
      wr(16'hff0c, ~dv); wr(16'hfe43, ~dp);
      repeat (5) @(posedge core_clk);
      rd(16'hff0c, dv);
      rd(16'hfe43, dp);
      rd(16'hffbc, (dd & dv) | (~dd & ek));
      @(negedge core_clk);
      chk(ape, ~addr_dir & ap, "apull");
      @(posedge core_clk);
    end
    {sw_standby, manual_reset} <= 2'b00;
    hw_standby <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(ape | dpe, 8'h00, "pulls");
    @(posedge core_clk);
    hw_standby <= 1'b0;
    @(posedge core_clk);
    rd(16'hff0c, 8'h00);
    rd(16'hfe43, 8'h00);
    rd(16'hfe42, 8'h00);
    close_out;
  end
endmodule // addr_data_port_pair_tb_top
